// ---- hdl/backplane_bus_controller.sv ----
// master and slave state machines of the backplane bus controller
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - slot match is sampled on the falling edge one cycle after a start cycle
// - local done low as slave drives ACK low on the next rising edge
// - transfer code latched on request; slave acknowledge shows current code inputs
// - hold at read acknowledge keeps data gate open until released
// - no second start cycle while hold is active
// - lock request with request issues attention lock after winning
// - releasing lock request issues attention null regardless of request
// - unlocked win waits at most 16 clocks for go, then null and rearbitrate
// - in lock mode attention lock first, then wait for go with no timeout
// - parked owner starts on go and request without arbitration
// - non-owner interrupt request passes to the bus line unclocked
// - request starts arbitration when this board is not master and not in fairness hold-off
// - slave grant with a pending access opens address gate, and data gate for writes
// - interim acknowledge request asserts TM0 during block transfers
// - contenders drive arbitration lines against their slot id; winner remains
// - parity valid stays inactive during master and slave cycles
// - start with ACK is attention; start alone begins transaction and contest
// - byte lanes decode from TM0 and inverted address bits
// - completion rises on slave ACK and holds while hold is active
// - locked slave flag one clock after start, never as master
// - bus reset passes a two stage synchroniser to the reset output
// - held modes take code at start, status at ACK, hold till next start
// - a winner does not request again until the request line clears
module backplane_bus_controller
  import bbc_pkg::*;
(
  input  wire logic                      i_core_clk,
  input  wire logic                      i_reset_n,
  input  wire logic                      i_bus_reset_n,
  input  wire logic [bbc_pkg::ID_W-1:0]  i_slot_id,
  input  wire logic                      i_slot_match_n,
  input  wire logic                      i_local_slave_done_n,
  input  wire logic                      i_local_xfer_code0,
  input  wire logic                      i_local_xfer_code1,
  input  wire logic                      i_master_keep_n,
  input  wire logic                      i_lock_tenure_req_n,
  input  wire logic                      i_master_go_n,
  input  wire logic                      i_nonowner_irq_in_n,
  input  wire logic                      i_local_bus_want_n,
  input  wire logic                      i_slave_resources_free_n,
  input  wire logic                      i_interim_ack_req_n,
  input  wire logic [1:0]                i_addr_inv,
  input  wire logic                      i_start_n,
  input  wire logic                      i_ack_n,
  input  wire logic                      i_rqst_n,
  input  wire logic [bbc_pkg::ID_W-1:0]  i_arb_n,
  input  wire logic [1:0]                i_tm_n,
  output logic                           o_start_n,
  output logic                           o_start_oe,
  output logic                           o_ack_n,
  output logic                           o_ack_oe,
  output logic                           o_rqst_n,
  output logic                           o_rqst_oe,
  output logic [bbc_pkg::ID_W-1:0]       o_arb_n,
  output logic [bbc_pkg::ID_W-1:0]       o_arb_oe,
  output logic [1:0]                     o_tm_n,
  output logic                           o_tm_oe,
  output logic                           o_spv_n,
  output logic                           o_spv_oe,
  output logic                           o_nmrq_n,
  output logic                           o_master_complete,
  output logic                           o_locked_as_slave,
  output logic                           o_synced_bus_reset_n,
  output logic                           o_held_xfer_mode0,
  output logic                           o_held_xfer_mode1,
  output logic                           o_owns_bus,
  output logic                           o_buffered_xfer_mode0,
  output logic                           o_buffered_xfer_mode1,
  output logic                           o_buffered_begin_n,
  output logic                           o_buffered_ack_n,
  output logic                           o_slave_access_pending_n,
  output logic                           o_byte_lane0_n,
  output logic                           o_byte_lane1_n,
  output logic                           o_byte_lane2_n,
  output logic                           o_byte_lane3_n,
  output logic                           o_local_data_gate_n,
  output logic                           o_local_addr_gate_n
);
  import bbc_pkg::*;

  function automatic logic owner(input master_state_e s);
    owner = (s == M_GRANT) || (s == M_ATTN) || (s == M_START) ||
            (s == M_WAIT_ACK) || (s == M_PARK);
  endfunction

  function automatic logic [3:0] lane_decode(input logic tm0, input logic [1:0] a);
    case ({tm0, a})
      3'h0:    lane_decode = LANES_BYTE0;
      3'h1:    lane_decode = LANES_BYTE1;
      3'h2:    lane_decode = LANES_BYTE2;
      3'h3:    lane_decode = LANES_BYTE3;
      3'h4:    lane_decode = LANES_WORD;
      3'h5:    lane_decode = LANES_HALF0;
      3'h6:    lane_decode = LANES_BLOCK;
      3'h7:    lane_decode = LANES_HALF1;
      default: lane_decode = LANES_NONE;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // falling edge samples
  // ----------------------------------------------------------------
  logic                smp_start, smp_ack, smp_rqst, smp_want, smp_go;
  logic                smp_lockreq, want_prev;
  logic [ID_W-1:0]     smp_arb_n;
  logic [1:0]          code_reg;
  logic                lockreq_lat;
  logic                rst_meta, rst_sync;

  always_ff @(negedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      smp_start <= 1'b0;
      smp_ack <= 1'b0;
      smp_rqst <= 1'b0;
      smp_want <= 1'b0;
      smp_go <= 1'b0;
      smp_lockreq <= 1'b0;
      want_prev <= 1'b0;
      smp_arb_n <= '1;
    end
    else
    begin
      smp_start <= ~i_start_n;
      smp_ack <= ~i_ack_n;
      smp_rqst <= ~i_rqst_n;
      smp_want <= ~i_local_bus_want_n;
      smp_go <= ~i_master_go_n;
      smp_lockreq <= ~i_lock_tenure_req_n;
      want_prev <= ~i_local_bus_want_n;
      smp_arb_n <= i_arb_n;
    end
  end

  // code and lock request caught when request is newly seen
  always_ff @(negedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      code_reg <= TM_IDLE_N;
      lockreq_lat <= 1'b0;
    end
    else if (!i_local_bus_want_n && !want_prev)
    begin
      code_reg <= {i_local_xfer_code1, i_local_xfer_code0};
      lockreq_lat <= ~i_lock_tenure_req_n;
    end
  end

  // bus reset synchroniser
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end
    else
    begin
      rst_meta <= i_bus_reset_n;
      rst_sync <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // master state machine
  // ----------------------------------------------------------------
  master_state_e        state_reg, state_next, ret_reg, ret_next;
  logic [1:0]           attn_reg, attn_next;
  logic                 lock_reg, lock_next;
  logic                 busy_reg, fair_reg;
  logic [GO_CNT_W-1:0]  go_cnt_reg, go_cnt_next;
  logic [CON_CNT_W-1:0] con_cnt_reg, con_cnt_next;
  logic [ID_W-1:0]      arb_pull;
  logic                 arb_won;
  logic                 mc_reg, slv_ack_reg, done_seen_reg;

  localparam logic [GO_CNT_W-1:0]  GO_LAST  = GO_CNT_W'(GO_WAIT_CLKS - 1);
  localparam logic [CON_CNT_W-1:0] CON_LAST = CON_CNT_W'(CONTEND_CLKS - 1);

  arb_contend #(.ID_W(ID_W)) u_arb (
    .i_own_id (i_slot_id),
    .i_arb_n  (smp_arb_n),
    .i_enable (state_reg == M_CONTEND),
    .o_pull   (arb_pull),
    .o_won    (arb_won)
  );

  wire smp_xact = smp_start & ~smp_ack;

  always_comb
  begin
    state_next = state_reg;
    ret_next = ret_reg;
    attn_next = attn_reg;
    lock_next = lock_reg;
    go_cnt_next = '0;
    con_cnt_next = '0;
    case (state_reg)
      M_IDLE:
        if (smp_want && !fair_reg)
          state_next = M_REQ;
      M_REQ:
        if (!smp_want)
          state_next = M_IDLE;
        else if (smp_xact || !busy_reg)
          state_next = M_CONTEND;
      M_CONTEND:
      begin
        con_cnt_next = con_cnt_reg + 1'b1;
        if (con_cnt_reg == CON_LAST)
          state_next = arb_won ? M_WAITFREE : M_REQ;
      end
      M_WAITFREE:
        if (!busy_reg)
        begin
          state_next = M_GRANT;
          lock_next = lockreq_lat;
        end
      M_GRANT:
        if (lock_reg)
        begin
          state_next = M_ATTN;
          attn_next = TM_ATTN_LOCK_N;
          ret_next = M_PARK;
        end
        else if (smp_go)
          state_next = M_START;
        else if (go_cnt_reg == GO_LAST)
        begin
          state_next = M_ATTN;
          attn_next = TM_ATTN_NULL_N;
          ret_next = M_IDLE;
        end
        else
          go_cnt_next = go_cnt_reg + 1'b1;
      M_ATTN:
        state_next = ret_reg;
      M_START:
        state_next = M_WAIT_ACK;
      M_WAIT_ACK:
        if (smp_ack && !smp_start)
          state_next = M_PARK;
      M_PARK:
        if (lock_reg && !smp_lockreq)
        begin
          state_next = M_ATTN;
          attn_next = TM_ATTN_NULL_N;
          ret_next = M_PARK;
          lock_next = 1'b0;
        end
        else if (smp_want && smp_go && !mc_reg)
          state_next = M_START;
        else if (smp_rqst && !lock_reg)
          state_next = M_IDLE;
      default:
        state_next = M_IDLE;
    endcase
    if (!rst_sync)
    begin
      state_next = M_IDLE;
      lock_next = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state_reg <= M_IDLE;
      ret_reg <= M_IDLE;
      attn_reg <= TM_ATTN_NULL_N;
      lock_reg <= 1'b0;
      go_cnt_reg <= '0;
      con_cnt_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      ret_reg <= ret_next;
      attn_reg <= attn_next;
      lock_reg <= lock_next;
      go_cnt_reg <= go_cnt_next;
      con_cnt_reg <= con_cnt_next;
    end
  end

  // bus busy between a transaction start and its ACK; fairness hold-off
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      busy_reg <= 1'b0;
      fair_reg <= 1'b0;
    end
    else
    begin
      busy_reg <= smp_xact | (busy_reg & ~(smp_ack & ~smp_start));
      fair_reg <= (state_next == M_WAITFREE) | (fair_reg & smp_rqst);
    end
  end

  // ----------------------------------------------------------------
  // bus drivers, rising edge
  // ----------------------------------------------------------------
  wire slv_ack_next = done_seen_reg & ~slv_ack_reg;
  wire own_start    = (state_next == M_START) | (state_next == M_ATTN);
  wire own_ack      = (state_next == M_ATTN) | slv_ack_next;
  wire interim_next;
  wire [1:0] tm_next = (state_next == M_ATTN)  ? attn_next :
                       (state_next == M_START) ? code_reg :
                       slv_ack_next ? {i_local_xfer_code1, i_local_xfer_code0} :
                       {1'b1, ~interim_next};
  wire rqst_next = (state_next == M_REQ) | (state_next == M_CONTEND) |
                   (state_next == M_WAITFREE) | (lock_next & owner(state_next));

  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_start_n <= 1'b1;
      o_start_oe <= 1'b0;
      o_ack_n <= 1'b1;
      o_ack_oe <= 1'b0;
      o_rqst_n <= 1'b1;
      o_rqst_oe <= 1'b0;
      o_arb_n <= '1;
      o_arb_oe <= '0;
      o_tm_n <= TM_IDLE_N;
      o_tm_oe <= 1'b0;
      o_spv_n <= 1'b1;
      o_spv_oe <= 1'b0;
      slv_ack_reg <= 1'b0;
    end
    else
    begin
      o_start_n <= ~own_start;
      o_start_oe <= own_start;
      o_ack_n <= ~own_ack;
      o_ack_oe <= own_ack;
      o_rqst_n <= ~rqst_next;
      o_rqst_oe <= rqst_next;
      o_arb_n <= (state_next == M_CONTEND) ? ~arb_pull : '1;
      o_arb_oe <= (state_next == M_CONTEND) ? arb_pull : '0;
      o_tm_n <= tm_next;
      o_tm_oe <= own_start | own_ack | interim_next;
      o_spv_n <= 1'b1;
      o_spv_oe <= own_start | own_ack | interim_next;
      slv_ack_reg <= slv_ack_next;
    end
  end

  assign o_nmrq_n = i_nonowner_irq_in_n;

  // ----------------------------------------------------------------
  // slave side and status, falling edge
  // ----------------------------------------------------------------
  logic after_start, pend_reg, lock_seen, slv_write, slv_block;
  logic interim_seen, rd_hold_reg;
  wire  pin_xact   = ~i_start_n & i_ack_n & ~o_start_oe;
  wire  pin_attn   = ~i_start_n & ~i_ack_n;
  wire  master_ack = (state_reg == M_WAIT_ACK) & ~i_ack_n & i_start_n;
  wire  keep_on    = ~i_master_keep_n;
  wire  grant_on   = pend_reg & ~i_slave_resources_free_n;
  assign interim_next = interim_seen & ~slv_ack_next;

  always_ff @(negedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      after_start <= 1'b0;
      pend_reg <= 1'b0;
      lock_seen <= 1'b0;
      slv_write <= 1'b0;
      slv_block <= 1'b0;
      done_seen_reg <= 1'b0;
      interim_seen <= 1'b0;
      o_locked_as_slave <= 1'b0;
    end
    else
    begin
      after_start <= pin_xact;
      if (pin_xact)
      begin
        slv_write <= ~i_tm_n[TM1_BIT];
        slv_block <= i_tm_n[TM0_BIT] & (i_addr_inv == ADDR_BLOCK);
      end
      if (pin_attn)
        lock_seen <= (i_tm_n == TM_ATTN_LOCK_N);
      if (after_start && !i_slot_match_n && !owner(state_reg))
        pend_reg <= 1'b1;
      else if (slv_ack_reg || !rst_sync)
        pend_reg <= 1'b0;
      done_seen_reg <= pend_reg & ~slv_ack_reg & ~i_local_slave_done_n;
      interim_seen <= pend_reg & slv_block & ~i_interim_ack_req_n;
      if (owner(state_reg) || (pin_attn && i_tm_n == TM_ATTN_NULL_N))
        o_locked_as_slave <= 1'b0;
      else if (after_start && !i_slot_match_n)
        o_locked_as_slave <= lock_seen;
    end
  end

  always_ff @(negedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      mc_reg <= 1'b0;
      rd_hold_reg <= 1'b0;
      o_master_complete <= 1'b0;
      o_owns_bus <= 1'b0;
      o_held_xfer_mode0 <= 1'b0;
      o_held_xfer_mode1 <= 1'b0;
      o_slave_access_pending_n <= 1'b1;
      o_local_addr_gate_n <= 1'b1;
      o_local_data_gate_n <= 1'b1;
      {o_byte_lane3_n, o_byte_lane2_n, o_byte_lane1_n, o_byte_lane0_n} <= LANES_NONE;
      o_buffered_begin_n <= 1'b1;
      o_buffered_ack_n <= 1'b1;
      o_buffered_xfer_mode0 <= 1'b0;
      o_buffered_xfer_mode1 <= 1'b0;
      o_synced_bus_reset_n <= 1'b0;
    end
    else
    begin
      mc_reg <= master_ack | (mc_reg & keep_on);
      o_master_complete <= master_ack | (mc_reg & keep_on);
      rd_hold_reg <= (master_ack & code_reg[TM1_BIT]) | (rd_hold_reg & keep_on);
      o_owns_bus <= owner(state_reg);
      if (pin_xact || (~i_start_n & i_ack_n & o_start_oe) || master_ack)
      begin
        o_held_xfer_mode0 <= ~i_tm_n[TM0_BIT];
        o_held_xfer_mode1 <= ~i_tm_n[TM1_BIT];
      end
      o_slave_access_pending_n <= ~pend_reg;
      o_local_addr_gate_n <= ~grant_on;
      o_local_data_gate_n <= ~((grant_on & slv_write) |
                               (master_ack & code_reg[TM1_BIT]) | (rd_hold_reg & keep_on));
      {o_byte_lane3_n, o_byte_lane2_n, o_byte_lane1_n, o_byte_lane0_n}
        <= lane_decode(i_tm_n[TM0_BIT], i_addr_inv);
      o_buffered_begin_n <= i_start_n;
      o_buffered_ack_n <= i_ack_n;
      o_buffered_xfer_mode0 <= ~i_tm_n[TM0_BIT];
      o_buffered_xfer_mode1 <= ~i_tm_n[TM1_BIT];
      o_synced_bus_reset_n <= rst_sync;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence attn_null_s;
    (state_reg == M_ATTN) && (o_tm_n == TM_ATTN_NULL_N) && !o_start_n && !o_ack_n;
  endsequence

  chk_spv_inactive: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    o_start_oe |-> (o_spv_oe && o_spv_n))
    else $error("parity valid driven active");
  chk_slave_ack: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (done_seen_reg && !slv_ack_reg) |=> (o_ack_oe && !o_ack_n && o_start_n))
    else $error("slave ack not driven after local done");
  chk_go_timeout: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (rst_sync && state_reg == M_GRANT && !lock_reg && !smp_go && go_cnt_reg == GO_LAST)
    |=> attn_null_s ##1 (state_reg == M_IDLE))
    else $error("go timeout did not end with null");
  chk_lock_attn: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (rst_sync && state_reg == M_GRANT && lock_reg)
    |=> (o_tm_n == TM_ATTN_LOCK_N && !o_start_n && !o_ack_n))
    else $error("lock attention missing");
  chk_unlock_null: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (rst_sync && state_reg == M_PARK && lock_reg && !smp_lockreq) |=> attn_null_s)
    else $error("unlock did not issue null");
  chk_held_no_start: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (state_reg == M_PARK && mc_reg) |=> (o_start_n || !o_ack_n))
    else $error("start issued while held");
  chk_complete_hold: assert property (@(negedge i_core_clk) disable iff (!i_reset_n)
    (o_master_complete && mc_reg && !i_master_keep_n) |=> o_master_complete)
    else $error("completion dropped during hold");
  chk_lock_not_master: assert property (@(negedge i_core_clk) disable iff (!i_reset_n)
    owner(state_reg) |=> !o_locked_as_slave)
    else $error("locked slave flag while master");
  chk_want_arb: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (rst_sync && state_reg == M_IDLE && smp_want && !fair_reg) |=> !o_rqst_n [*2])
    else $error("request did not start arbitration");
endmodule
`default_nettype wire

// ---- hdl/bbc_pkg.sv ----
// shared constants and types of the backplane bus controller
package bbc_pkg;

  localparam int          ID_W          = 4;
  localparam int          GO_WAIT_CLKS  = 16;
  localparam int          GO_CNT_W      = 5;
  localparam int          CONTEND_CLKS  = 2;
  localparam int          CON_CNT_W     = 2;
  localparam int          TM0_BIT       = 0;
  localparam int          TM1_BIT       = 1;
  // pin levels of TM1..TM0 during attention cycles and at idle
  localparam logic [1:0]  TM_ATTN_NULL_N = 2'h3;
  localparam logic [1:0]  TM_ATTN_LOCK_N = 2'h2;
  localparam logic [1:0]  TM_IDLE_N      = 2'h3;
  // byte lane patterns, bit 3 = lane 3, low = lane active
  localparam logic [3:0]  LANES_BYTE0   = 4'hE;
  localparam logic [3:0]  LANES_BYTE1   = 4'hD;
  localparam logic [3:0]  LANES_BYTE2   = 4'hB;
  localparam logic [3:0]  LANES_BYTE3   = 4'h7;
  localparam logic [3:0]  LANES_WORD    = 4'h0;
  localparam logic [3:0]  LANES_HALF0   = 4'hC;
  localparam logic [3:0]  LANES_HALF1   = 4'h3;
  localparam logic [3:0]  LANES_BLOCK   = 4'h0;
  localparam logic [3:0]  LANES_NONE    = 4'hF;
  localparam logic [1:0]  ADDR_BLOCK    = 2'h2;

  typedef enum logic [3:0] {
    M_IDLE     = 4'h0,
    M_REQ      = 4'h1,
    M_CONTEND  = 4'h2,
    M_WAITFREE = 4'h3,
    M_GRANT    = 4'h4,
    M_ATTN     = 4'h5,
    M_START    = 4'h6,
    M_WAIT_ACK = 4'h7,
    M_PARK     = 4'h8
  } master_state_e;

endpackage

// ---- hdl/arb_contend.sv ----
// distributed arbitration driver for the four arbitration lines
`timescale 1ns/1ps
`default_nettype none
module arb_contend #(
  parameter int ID_W = 4
) (
  input  wire logic [ID_W-1:0] i_own_id,
  input  wire logic [ID_W-1:0] i_arb_n,
  input  wire logic            i_enable,
  output logic      [ID_W-1:0] o_pull,
  output logic                 o_won
);
  logic [ID_W-1:0] lose_at;

  // a line is released once a higher line shows a bit this slot lacks
  genvar g;
  generate
    for (g = 0; g < ID_W; g++)
    begin : g_line
      if (g == ID_W - 1)
      begin : g_top
        assign lose_at[g] = 1'b0;
      end
      else
      begin : g_low
        assign lose_at[g] = lose_at[g+1] | (~i_arb_n[g+1] & ~i_own_id[g+1]);
      end
      assign o_pull[g] = i_enable & i_own_id[g] & ~lose_at[g];
    end
  endgenerate

  assign o_won = i_enable & ((~i_arb_n) == i_own_id);
endmodule
`default_nettype wire

// ---- tb/bus_far_end.sv ----
// far side of the backplane: a remote master start and a responding slave
`timescale 1ns/1ps
`default_nettype none
module bus_far_end (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic start_n,
  input  wire logic start_oe,
  input  wire logic ack_n,
  input  wire logic ack_oe,
  input  wire logic far_go,
  output logic      far_start,
  output logic      far_ack
);
  logic       txn;
  logic [1:0] dly;
  // start without ACK from the controller is a transaction to answer
  assign txn = start_oe & ~start_n & ~(ack_oe & ~ack_n);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      {far_start, far_ack, dly} <= 4'h0;
    else
    begin
      far_start <= far_go;
      far_ack   <= (dly == 2'h1);
      dly       <= txn ? 2'h2 : ((dly != 2'h0) ? dly - 2'h1 : 2'h0);
    end
  end
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench of the backplane bus controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import bbc_pkg::*;
  logic i_core_clk, i_reset_n, i_bus_reset_n, i_slot_match_n, i_local_slave_done_n, far_go;
  logic i_local_xfer_code0, i_local_xfer_code1, i_master_keep_n, i_lock_tenure_req_n, far_rqst;
  logic i_master_go_n, i_nonowner_irq_in_n, i_local_bus_want_n, i_slave_resources_free_n;
  logic i_interim_ack_req_n, i_start_n, i_ack_n, i_rqst_n, o_start_n, o_start_oe, o_ack_n;
  logic o_ack_oe, o_rqst_n, o_rqst_oe, o_tm_oe, o_spv_n, o_spv_oe, o_nmrq_n, o_master_complete;
  logic o_locked_as_slave, o_synced_bus_reset_n, o_held_xfer_mode0, o_held_xfer_mode1;
  logic o_owns_bus, o_buffered_xfer_mode0, o_buffered_xfer_mode1, o_buffered_begin_n;
  logic o_buffered_ack_n, o_slave_access_pending_n, o_byte_lane0_n, o_byte_lane1_n;
  logic o_byte_lane2_n, o_byte_lane3_n, o_local_data_gate_n, o_local_addr_gate_n;
  logic far_start, far_ack;
  logic [3:0] i_slot_id, i_arb_n, o_arb_n, o_arb_oe;
  logic [1:0] i_addr_inv, i_tm_n, o_tm_n, start_tm, ack_tm;
  int errors, check_count, n_start, n_null, n_lock, n_ack, n_spv, n_rq, k;
  wire d_st = o_start_oe & ~o_start_n;
  wire d_ak = o_ack_oe & ~o_ack_n;
  backplane_bus_controller i_backplane_bus_controller (.*);
  bus_far_end i_bus_far_end (.clk(i_core_clk), .rst_n(i_reset_n), .start_n(o_start_n),
    .start_oe(o_start_oe), .ack_n(o_ack_n), .ack_oe(o_ack_oe), .far_go, .far_start, .far_ack);
  // wired open-drain lines rest high on their pull-ups
  assign i_start_n = ~(d_st | far_start);
  assign i_ack_n = ~(d_ak | far_ack);
  assign i_rqst_n = ~((o_rqst_oe & ~o_rqst_n) | far_rqst);
  assign i_arb_n = ~(o_arb_oe & ~o_arb_n);
  assign i_tm_n = o_tm_oe ? o_tm_n : 2'h3;
  always @(negedge i_core_clk)
  begin
    if (d_st & ~d_ak) start_tm <= o_tm_n;
    if (d_ak & ~d_st) ack_tm <= o_tm_n;
    n_start <= n_start + int'(d_st & ~d_ak);
    n_null <= n_null + int'(d_st & d_ak & (o_tm_n == TM_ATTN_NULL_N));
    n_lock <= n_lock + int'(d_st & d_ak & (o_tm_n == TM_ATTN_LOCK_N));
    n_ack <= n_ack + int'(d_ak & ~d_st);
    n_spv <= n_spv + int'(o_spv_oe & ~o_spv_n);
    n_rq <= n_rq + int'(o_rqst_oe & ~o_rqst_n);
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  task automatic end_sim;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic t_reset;
    i_nonowner_irq_in_n <= 1'b0;
    i_bus_reset_n <= 1'b0;
    #2 check(o_nmrq_n, 0);
    cyc(3);
    check(o_synced_bus_reset_n, 0);
    i_bus_reset_n <= 1'b1;
    cyc(4);
    check(o_synced_bus_reset_n, 1);
  endtask
  task automatic t_timeout;
    int s = n_start;
    int z = n_null;
    i_local_bus_want_n <= 1'b0;
    for (k = 0; k < 40 && !o_owns_bus; k++) cyc(1);
    for (k = 0; k < 40 && n_null == z; k++) cyc(1);
    i_local_bus_want_n <= 1'b1;
    check(k >= 15 && k <= 19, 1);
    check(n_start - s, 0);
    cyc(40);
  endtask
  task automatic t_lock;
    int s = n_start;
    int z = n_null;
    int l = n_lock;
    i_lock_tenure_req_n <= 1'b0;
    i_local_bus_want_n <= 1'b0;
    cyc(40);
    check(n_lock - l, 1);
    check(n_null - z + n_start - s, 0);
    i_master_go_n <= 1'b0;
    for (k = 0; k < 20 && !o_master_complete; k++) cyc(1);
    i_local_bus_want_n <= 1'b1;
    i_master_go_n <= 1'b1;
    check(n_start - s, 1);
    i_lock_tenure_req_n <= 1'b1;
    cyc(6);
    check(n_null - z, 1);
  endtask
  task automatic t_hold;
    int s = n_start;
    int r = n_rq;
    {i_local_xfer_code1, i_local_xfer_code0} <= 2'h3;
    i_master_keep_n <= 1'b0;
    i_local_bus_want_n <= 1'b0;
    i_master_go_n <= 1'b0;
    for (k = 0; k < 20 && !o_master_complete; k++) cyc(1);
    cyc(8);
    check(start_tm, 2'h3);
    check(n_start - s, 1);
    check(n_rq - r, 0);
    check({o_master_complete, o_local_data_gate_n}, 2'h2);
    {i_master_keep_n, i_local_bus_want_n, i_master_go_n} <= 3'h7;
    cyc(3);
    check({o_master_complete, o_local_data_gate_n}, 2'h1);
    // new code loaded after a high request pulse, status held after ACK
    {i_local_xfer_code1, i_local_xfer_code0, i_local_bus_want_n, i_master_go_n} <= 4'h0;
    for (k = 0; k < 8 && n_start == s + 1; k++) cyc(1);
    {i_local_bus_want_n, i_master_go_n} <= 2'h3;
    cyc(6);
    check({start_tm, o_held_xfer_mode1, o_held_xfer_mode0}, 4'h0);
  endtask
  task automatic t_slave;
    int a = n_ack;
    far_rqst <= 1'b1;
    cyc(4);
    far_rqst <= 1'b0;
    {i_local_xfer_code1, i_local_xfer_code0} <= 2'h1;
    {i_slot_match_n, i_slave_resources_free_n, far_go} <= 3'h1;
    i_addr_inv <= 2'h2;
    cyc(1);
    far_go <= 1'b0;
    cyc(4);
    check({o_slave_access_pending_n, o_local_addr_gate_n, o_locked_as_slave, o_owns_bus}, 4'h0);
    i_interim_ack_req_n <= 1'b0;
    cyc(2);
    check({o_tm_oe, o_tm_n}, 3'h6);
    i_interim_ack_req_n <= 1'b1;
    i_local_slave_done_n <= 1'b0;
    for (k = 0; k < 8 && n_ack == a; k++) cyc(1);
    {i_local_slave_done_n, i_slot_match_n, i_slave_resources_free_n} <= 3'h7;
    check({o_buffered_ack_n, o_buffered_begin_n, o_buffered_xfer_mode1, o_buffered_xfer_mode0}, 4'h6);
    check(n_ack - a, 1);
    check(ack_tm, 2'h1);
    cyc(3);
    check({o_local_addr_gate_n, 7'(n_spv)}, 8'h80);
    i_addr_inv <= 2'h1;
    cyc(2);
    check({o_byte_lane3_n, o_byte_lane2_n, o_byte_lane1_n, o_byte_lane0_n}, LANES_HALF0);
  endtask
  initial
  begin
    i_core_clk = 1'b0;
    forever #4 i_core_clk = ~i_core_clk;
  end
  initial
  begin
    {i_reset_n, far_go, far_rqst, i_local_xfer_code0, i_local_xfer_code1} = '0;
    {i_bus_reset_n, i_slot_match_n, i_local_slave_done_n, i_master_keep_n, i_master_go_n,
      i_lock_tenure_req_n, i_nonowner_irq_in_n, i_local_bus_want_n, i_interim_ack_req_n,
      i_slave_resources_free_n} = '1;
    i_slot_id = 4'h5;
    i_addr_inv = 2'h0;
    cyc(6);
    i_reset_n <= 1'b1;
    cyc(4);
    t_reset;
    t_timeout;
    t_lock;
    t_hold;
    t_slave;
    end_sim;
  end
  initial
  begin
    #100us;
    errors++;
    end_sim;
  end
endmodule
`default_nettype wire
